// >>> hdl/ccs_regs.sv
// Purpose: trap vector base, product upper word, icache control and fp status registers
// Assumes: all inputs come from logic on ref_clk_i; rst_i is the power-on reset
// Notes: software reads answer one cycle after the request
`timescale 1ns/1ps

// How it works
// - taking a trap loads the pc from the vector base field and the incoming trap cause
// - bits 31..12 hold the software base of the trap table
// - a reset trap ignores the base and sends the pc to zero
// - bits 11..4 hold the trap cause, written only when a trap is taken
// - software writes change only the base; bits 3..0 read zero
// - multiply puts the product's upper 32 bits into the upper word register
// - divide takes its dividend's upper 32 bits from the upper word register
// - the upper word register is read and written without privilege checks
// - icache control access outside supervisor mode raises a privilege exception
// - icache control is ancillary register number 31
// - control bit 0 enables icache accesses
// - bit 1 set invalidates flush hits; clear takes flush trap 25
// - power-on reset clears both control bits and invalidates the icache
// - other icache control bits ignore writes and read zero
// - fp status bits 31..30 pick the rounding direction
// - fp status bits 29..28, 21..20 and 12 read zero, ignore writes
// - trap mask ANDed with current exceptions forces an fp trap
// - fp status bit 22 selects nonstandard mode, software read and write
// - bits 19..17 hold a fixed version that ignores writes
// - bits 16..14 give the fp trap type, updated per operation only
// - bit 13 reads one while the fp queue holds entries
// - bits 11..10 hold the fp compare result, software read and write
// - current exceptions update per operation; masked ones accumulate stickily
// - processor state bit 7 marks supervisor mode
module ccs_regs #(
  parameter logic [2:0] FP_VERSION = 3'h5 // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // software access
  input wire logic sw_rd_i,
  input wire logic sw_wr_i,
  input wire ccs_pkg::ccs_sel_type sw_sel_i,
  input wire logic [4:0] sw_asr_num_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic [31:0] proc_state_i,
  output logic [31:0] sw_rdata_o,
  output logic sw_rvalid_o,
  output logic priv_exc_o,
  // traps
  input wire logic trap_take_i,
  input wire logic trap_reset_i,
  input wire logic [7:0] trap_cause_i,
  output logic [31:0] trap_pc_o,
  output logic trap_pc_valid_o,
  // multiply and divide
  input wire logic mul_done_i,
  input wire logic [31:0] mul_upper_i,
  output logic [31:0] div_upper_o,
  // instruction cache
  input wire logic flush_i,
  input wire logic flush_hit_i,
  output logic icache_enable_o,
  output logic flush_inval_o,
  output logic flush_trap_o,
  output logic [7:0] flush_trap_cause_o,
  output logic icache_inval_all_o,
  // floating point
  input wire logic fp_done_i,
  input wire logic [4:0] fp_exc_i,
  input wire logic [2:0] fp_ftt_i,
  input wire logic fp_fcc_wr_i,
  input wire logic [1:0] fp_fcc_i,
  input wire logic fp_queue_busy_i,
  output logic [1:0] fp_round_mode_o,
  output logic relaxed_ieee_mode_o,
  output logic fp_trap_o
);
  import ccs_pkg::*;

  logic [19:0] vector_base_field;
  logic [7:0] trap_cause_field;
  logic [31:0] upper_word;
  logic icache_enable;
  logic flush_invalidate_enable;
  logic [1:0] round_mode;
  logic [4:0] trap_enable_mask;
  logic relaxed_ieee_mode;
  logic [2:0] fp_trap_type;
  logic [1:0] fp_cond;
  logic [4:0] sticky_exception_flags;
  logic [4:0] latest_exception_flags;

  logic is_super;
  logic asr_hit;
  logic icc_ok;
  logic icc_denied;
  logic vb_wr;
  logic uw_wr;
  logic icc_wr;
  logic fps_wr;
  logic [31:0] vector_base_word;
  logic [31:0] icc_word;
  logic [31:0] fps_word;
  logic [31:0] next_rdata;
  logic rd_ok;
  logic [4:0] masked_exc;
  logic fp_trap_hit;

  // icache control select and privilege
  assign is_super = proc_state_i[STATE_SUPER_BIT];
  assign asr_hit = (sw_sel_i == CCS_SEL_ANCILLARY)
    && (sw_asr_num_i == ICACHE_CTRL_ASR);
  assign icc_ok = asr_hit && is_super;
  assign icc_denied = asr_hit && !is_super && (sw_rd_i || sw_wr_i);
  assign vb_wr = sw_wr_i && (sw_sel_i == CCS_SEL_VECTOR_BASE);
  assign uw_wr = sw_wr_i && (sw_sel_i == CCS_SEL_UPPER_WORD);
  assign icc_wr = sw_wr_i && icc_ok;
  assign fps_wr = sw_wr_i && (sw_sel_i == CCS_SEL_FP_STATUS);
  assign rd_ok = sw_rd_i && !icc_denied;
  // untrapped exceptions feed the sticky flags
  assign masked_exc = fp_exc_i & ~trap_enable_mask;
  assign fp_trap_hit = |(fp_exc_i & trap_enable_mask);

  // low nibble is always zero
  assign vector_base_word = {vector_base_field, trap_cause_field, 4'h0};

  // only the two control bits are stored
  always_comb begin
    icc_word = 32'h0000_0000;
    icc_word[ICC_ENABLE_BIT] = icache_enable;
    icc_word[ICC_FLUSH_INV_BIT] = flush_invalidate_enable;
  end

  // unused and reserved bits stay zero
  always_comb begin
    fps_word = 32'h0000_0000;
    fps_word[FPS_RD_MSB:FPS_RD_LSB] = round_mode;
    fps_word[FPS_MASK_MSB:FPS_MASK_LSB] = trap_enable_mask;
    fps_word[FPS_RELAX_BIT] = relaxed_ieee_mode;
    fps_word[FPS_VER_MSB:FPS_VER_LSB] = FP_VERSION;
    fps_word[FPS_FTT_MSB:FPS_FTT_LSB] = fp_trap_type;
    fps_word[FPS_QNE_BIT] = fp_queue_busy_i;
    fps_word[FPS_FCC_MSB:FPS_FCC_LSB] = fp_cond;
    fps_word[FPS_STICKY_MSB:FPS_STICKY_LSB] = sticky_exception_flags;
    fps_word[FPS_LATEST_MSB:FPS_LATEST_LSB] = latest_exception_flags;
  end

  // read mux; a denied icache access reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (sw_sel_i)
      CCS_SEL_VECTOR_BASE: begin
        next_rdata = vector_base_word;
      end
      CCS_SEL_UPPER_WORD: begin
        next_rdata = upper_word;
      end
      CCS_SEL_ANCILLARY: begin
        if (icc_ok) begin
          next_rdata = icc_word;
        end
      end
      CCS_SEL_FP_STATUS: begin
        next_rdata = fps_word;
      end
    endcase
  end

  // software read port and privilege check
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sw_rdata_o <= 32'h0000_0000;
      sw_rvalid_o <= 1'b0;
      priv_exc_o <= 1'b0;
    end else begin
      sw_rvalid_o <= rd_ok;
      sw_rdata_o <= rd_ok ? next_rdata : 32'h0000_0000;
      priv_exc_o <= icc_denied;
    end
  end

  // trap vector base register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      vector_base_field <= TVB_BASE_RESET;
      trap_cause_field <= TVB_CAUSE_RESET;
    end else begin
      if (vb_wr) begin
        vector_base_field <= sw_wdata_i[TVB_BASE_MSB:TVB_BASE_LSB];
      end
      // a reset trap leaves the cause field alone
      if (trap_take_i && !trap_reset_i) begin
        trap_cause_field <= trap_cause_i;
      end
    end
  end

  // trap program counter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trap_pc_o <= RESET_TRAP_PC;
      trap_pc_valid_o <= 1'b0;
    end else begin
      trap_pc_valid_o <= trap_take_i;
      if (trap_take_i) begin
        if (trap_reset_i) begin
          trap_pc_o <= RESET_TRAP_PC;
        end else begin
          trap_pc_o <= {vector_base_field, trap_cause_i, 4'h0};
        end
      end
    end
  end

  // product upper word; multiply result wins over a software write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      upper_word <= UPPER_WORD_RESET;
    end else if (mul_done_i) begin
      upper_word <= mul_upper_i;
    end else if (uw_wr) begin
      upper_word <= sw_wdata_i;
    end
  end

  // divide sees the same word as the upper word register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_upper_o <= UPPER_WORD_RESET;
    end else if (mul_done_i) begin
      div_upper_o <= mul_upper_i;
    end else if (uw_wr) begin
      div_upper_o <= sw_wdata_i;
    end
  end

  // icache control register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      icache_enable <= 1'b0;
      flush_invalidate_enable <= 1'b0;
    end else if (icc_wr) begin
      icache_enable <= sw_wdata_i[ICC_ENABLE_BIT];
      flush_invalidate_enable <= sw_wdata_i[ICC_FLUSH_INV_BIT];
    end
  end

  // registered enable copy and power-on invalidate
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      icache_enable_o <= 1'b0;
      icache_inval_all_o <= 1'b1;
    end else begin
      icache_enable_o <= icc_wr ? sw_wdata_i[ICC_ENABLE_BIT] : icache_enable;
      icache_inval_all_o <= 1'b0;
    end
  end

  // flush handling
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flush_inval_o <= 1'b0;
      flush_trap_o <= 1'b0;
      flush_trap_cause_o <= TVB_CAUSE_RESET;
    end else begin
      flush_inval_o <= flush_i && flush_hit_i && flush_invalidate_enable;
      flush_trap_o <= flush_i && !flush_invalidate_enable;
      flush_trap_cause_o <= FLUSH_TRAP_CAUSE;
    end
  end

  // fp status software fields
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      round_mode <= FPS_RD_RESET;
      trap_enable_mask <= FPS_MASK_RESET;
      relaxed_ieee_mode <= 1'b0;
    end else if (fps_wr) begin
      round_mode <= sw_wdata_i[FPS_RD_MSB:FPS_RD_LSB];
      trap_enable_mask <= sw_wdata_i[FPS_MASK_MSB:FPS_MASK_LSB];
      relaxed_ieee_mode <= sw_wdata_i[FPS_RELAX_BIT];
    end
  end

  // registered copies of rounding and mode bits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fp_round_mode_o <= RND_NEAREST;
      relaxed_ieee_mode_o <= 1'b0;
    end else if (fps_wr) begin
      fp_round_mode_o <= sw_wdata_i[FPS_RD_MSB:FPS_RD_LSB];
      relaxed_ieee_mode_o <= sw_wdata_i[FPS_RELAX_BIT];
    end
  end

  // trap type follows every operation; loads leave it alone
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fp_trap_type <= FPS_FTT_RESET;
    end else if (fp_done_i) begin
      fp_trap_type <= fp_ftt_i;
    end
  end

  // compare result: the datapath wins over a load
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fp_cond <= FPS_FCC_RESET;
    end else if (fp_fcc_wr_i) begin
      fp_cond <= fp_fcc_i;
    end else if (fps_wr) begin
      fp_cond <= sw_wdata_i[FPS_FCC_MSB:FPS_FCC_LSB];
    end
  end

  // exception flags; completing operations win the latest flags over a load and OR into loaded sticky flags
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      latest_exception_flags <= FPS_EXC_RESET;
      sticky_exception_flags <= FPS_EXC_RESET;
    end else begin
      if (fp_done_i) begin
        latest_exception_flags <= fp_exc_i;
      end else if (fps_wr) begin
        latest_exception_flags <= sw_wdata_i[FPS_LATEST_MSB:FPS_LATEST_LSB];
      end
      if (fps_wr) begin
        sticky_exception_flags <= sw_wdata_i[FPS_STICKY_MSB:FPS_STICKY_LSB]
          | (fp_done_i ? masked_exc : 5'h00);
      end else if (fp_done_i) begin
        sticky_exception_flags <= sticky_exception_flags
          | masked_exc;
      end
    end
  end

  // fp trap raised only when an operation completes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fp_trap_o <= 1'b0;
    end else begin
      fp_trap_o <= fp_done_i && fp_trap_hit;
    end
  end
endmodule

// >>> hdl/ccs_pkg.sv
// Purpose: shared constants for the cpu control and status register bank
// Assumes: 32-bit registers, one processor clock
// Notes: field positions are given as msb/lsb pairs
package ccs_pkg;
  localparam int unsigned DATA_W = 32;

  // software register select codes
  typedef enum logic [1:0] {
    CCS_SEL_VECTOR_BASE = 2'h0,
    CCS_SEL_UPPER_WORD = 2'h1,
    CCS_SEL_ANCILLARY = 2'h2,
    CCS_SEL_FP_STATUS = 2'h3
  } ccs_sel_type;

  // ancillary register number of the icache control register
  localparam logic [4:0] ICACHE_CTRL_ASR = 5'h1f;
  // supervisor bit within the processor state word
  localparam int unsigned STATE_SUPER_BIT = 7;

  // trap vector base register fields
  localparam int unsigned TVB_BASE_MSB = 31;
  localparam int unsigned TVB_BASE_LSB = 12;
  localparam int unsigned TVB_CAUSE_MSB = 11;
  localparam int unsigned TVB_CAUSE_LSB = 4;
  localparam logic [19:0] TVB_BASE_RESET = 20'h0_0000;
  localparam logic [7:0] TVB_CAUSE_RESET = 8'h00;
  localparam logic [31:0] RESET_TRAP_PC = 32'h0000_0000;

  localparam logic [31:0] UPPER_WORD_RESET = 32'h0000_0000;

  // icache control bits
  localparam int unsigned ICC_ENABLE_BIT = 0;
  localparam int unsigned ICC_FLUSH_INV_BIT = 1;
  localparam logic [7:0] FLUSH_TRAP_CAUSE = 8'h19;

  // fp status fields
  localparam int unsigned FPS_RD_MSB = 31;
  localparam int unsigned FPS_RD_LSB = 30;
  localparam int unsigned FPS_MASK_MSB = 27;
  localparam int unsigned FPS_MASK_LSB = 23;
  localparam int unsigned FPS_RELAX_BIT = 22;
  localparam int unsigned FPS_VER_MSB = 19;
  localparam int unsigned FPS_VER_LSB = 17;
  localparam int unsigned FPS_FTT_MSB = 16;
  localparam int unsigned FPS_FTT_LSB = 14;
  localparam int unsigned FPS_QNE_BIT = 13;
  localparam int unsigned FPS_FCC_MSB = 11;
  localparam int unsigned FPS_FCC_LSB = 10;
  localparam int unsigned FPS_STICKY_MSB = 9;
  localparam int unsigned FPS_STICKY_LSB = 5;
  localparam int unsigned FPS_LATEST_MSB = 4;
  localparam int unsigned FPS_LATEST_LSB = 0;
  localparam logic [1:0] FPS_RD_RESET = 2'h0;
  localparam logic [4:0] FPS_MASK_RESET = 5'h00;
  localparam logic [4:0] FPS_EXC_RESET = 5'h00;
  localparam logic [2:0] FPS_FTT_RESET = 3'h0;
  localparam logic [1:0] FPS_FCC_RESET = 2'h0;

  // rounding direction codes
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_ZERO = 2'h1;
  localparam logic [1:0] RND_POS_INF = 2'h2;
  localparam logic [1:0] RND_NEG_INF = 2'h3;
endpackage

// >>> tb/ccs_regs_chk.sv
// Purpose: concurrent checks on the control and status register bank ports
// Assumes: one clock, synchronous active high reset
// Notes: bound onto ccs_regs after the module
`timescale 1ns/1ps
module ccs_regs_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sw_rd_i,
  input wire logic sw_wr_i,
  input wire ccs_pkg::ccs_sel_type sw_sel_i,
  input wire logic [4:0] sw_asr_num_i,
  input wire logic [31:0] proc_state_i,
  input wire logic [31:0] sw_rdata_o,
  input wire logic sw_rvalid_o,
  input wire logic priv_exc_o,
  input wire logic trap_take_i,
  input wire logic trap_reset_i,
  input wire logic [7:0] trap_cause_i,
  input wire logic [31:0] trap_pc_o,
  input wire logic trap_pc_valid_o,
  input wire logic mul_done_i,
  input wire logic [31:0] mul_upper_i,
  input wire logic [31:0] div_upper_o,
  input wire logic flush_i,
  input wire logic flush_trap_o,
  input wire logic [7:0] flush_trap_cause_o,
  input wire logic icache_inval_all_o,
  input wire logic fp_done_i,
  input wire logic [4:0] fp_exc_i,
  input wire logic fp_queue_busy_i,
  input wire logic fp_trap_o
);
  import ccs_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic denied;
  assign denied = sw_sel_i == CCS_SEL_ANCILLARY && sw_asr_num_i == ICACHE_CTRL_ASR &&
    !proc_state_i[STATE_SUPER_BIT];
  a_trap_answer: assert property (trap_take_i |=> trap_pc_valid_o)
    else $error("trap pc valid missing");
  a_reset_trap_zero: assert property (trap_take_i && trap_reset_i |=>
    trap_pc_o == 32'h0)
    else $error("reset trap pc not zero");
  a_trap_cause_pc: assert property (trap_take_i && !trap_reset_i |=>
    trap_pc_o[11:0] == {$past(trap_cause_i), 4'h0})
    else $error("trap pc cause bits wrong");
  a_priv_denied: assert property ((sw_rd_i || sw_wr_i) && denied |=>
    priv_exc_o && !sw_rvalid_o)
    else $error("privileged access not refused");
  a_read_answer: assert property (sw_rd_i && !denied |=> sw_rvalid_o && !priv_exc_o)
    else $error("read answer missing");
  a_flush_trap_src: assert property (flush_trap_o |->
    $past(flush_i) && flush_trap_cause_o == FLUSH_TRAP_CAUSE)
    else $error("flush trap without flush");
  a_fp_trap_src: assert property (fp_trap_o |->
    $past(fp_done_i) && $past(fp_exc_i) != 5'h0)
    else $error("fp trap without exception");
  a_mul_to_div: assert property (mul_done_i |=> div_upper_o == $past(mul_upper_i))
    else $error("upper word not loaded by multiply");
  a_fp_read_zero: assert property (sw_rd_i && !sw_wr_i &&
    sw_sel_i == CCS_SEL_FP_STATUS |=> (sw_rdata_o & 32'h3030_1000) == 32'h0 &&
    sw_rdata_o[13] == $past(fp_queue_busy_i))
    else $error("fp status fixed bits wrong");
  a_inval_released: assert property (!$past(rst_i) |-> !icache_inval_all_o)
    else $error("invalidate all held after reset");
  c_trap: cover property (trap_take_i && !trap_reset_i);
  c_priv: cover property (sw_wr_i && denied);
  c_fp_trap: cover property (fp_trap_o);
endmodule

bind ccs_regs ccs_regs_chk i_ccs_regs_chk (.*);

// >>> tb/tb.sv
// Purpose: directed register access tests for the control and status bank
// Assumes: inputs change at the falling clock edge
// Notes: reads answer one cycle after the request
`timescale 1ns/1ps
module tb;
  import ccs_pkg::*;
  localparam logic [2:0] FPV = 3'h5; // arbitrary value
  localparam logic [31:0] VER = {12'h0, FPV, 17'h0};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sw_rd_i = 1'b0, sw_wr_i = 1'b0, trap_take_i = 1'b0, trap_reset_i = 1'b0;
  logic mul_done_i = 1'b0, flush_i = 1'b0, flush_hit_i = 1'b0, fp_done_i = 1'b0;
  logic fp_fcc_wr_i = 1'b0, fp_queue_busy_i = 1'b0;
  ccs_sel_type sw_sel_i = CCS_SEL_VECTOR_BASE;
  logic [4:0] sw_asr_num_i = 5'h0, fp_exc_i = 5'h0;
  logic [31:0] sw_wdata_i = 32'h0, proc_state_i = 32'h0, mul_upper_i = 32'h0;
  logic [7:0] trap_cause_i = 8'h0;
  logic [2:0] fp_ftt_i = 3'h0;
  logic [1:0] fp_fcc_i = 2'h0;
  logic [31:0] sw_rdata_o, trap_pc_o, div_upper_o;
  logic sw_rvalid_o, priv_exc_o, trap_pc_valid_o, icache_enable_o, flush_inval_o;
  logic flush_trap_o, icache_inval_all_o, relaxed_ieee_mode_o, fp_trap_o;
  logic [7:0] flush_trap_cause_o;
  logic [1:0] fp_round_mode_o;
  int error_cnt = 0;
  int samples_checked = 0;

  ccs_regs #(.FP_VERSION(FPV)) i_ccs_regs (.*);

  always #20 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step;
    @(negedge ref_clk_i);
  endtask

  task automatic wr(input ccs_sel_type s, input logic [31:0] v);
    step();
    sw_wr_i = 1'b1;
    sw_sel_i = s;
    sw_wdata_i = v;
    step();
    sw_wr_i = 1'b0;
  endtask

  task automatic rd(input ccs_sel_type s, input logic [31:0] exp, input logic ok = 1'b1);
    step();
    sw_rd_i = 1'b1;
    sw_sel_i = s;
    step();
    sw_rd_i = 1'b0;
    chk(32'(sw_rvalid_o), 32'(ok));
    chk(sw_rdata_o, exp);
  endtask

  task automatic trap(input logic r, input logic [7:0] c, input logic [31:0] pc);
    step();
    trap_take_i = 1'b1;
    trap_reset_i = r;
    trap_cause_i = c;
    step();
    trap_take_i = 1'b0;
    chk(32'(trap_pc_valid_o), 32'h1);
    chk(trap_pc_o, pc);
  endtask

  task automatic flush(input logic [1:0] e);
    step();
    flush_i = 1'b1;
    step();
    flush_i = 1'b0;
    chk(32'({flush_inval_o, flush_trap_o}), 32'(e));
  endtask

  task automatic fpop(input logic [4:0] e, input logic [2:0] t, input logic x);
    step();
    fp_done_i = 1'b1;
    fp_exc_i = e;
    fp_ftt_i = t;
    step();
    fp_done_i = 1'b0;
    chk(32'(fp_trap_o), 32'(x));
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (2) step();
    chk(32'(icache_inval_all_o), 32'h1);
    rst_i = 1'b0;
    step();
    chk(32'(icache_inval_all_o), 32'h0);
    chk(32'(flush_trap_cause_o), 32'h19);
    sw_asr_num_i = ICACHE_CTRL_ASR;
    proc_state_i = 32'h80;
    rd(CCS_SEL_VECTOR_BASE, 32'h0);
    rd(CCS_SEL_ANCILLARY, 32'h0);
    rd(CCS_SEL_FP_STATUS, VER);
    wr(CCS_SEL_VECTOR_BASE, 32'hffff_ffff);
    rd(CCS_SEL_VECTOR_BASE, 32'hffff_f000);
    trap(1'b0, 8'h5a, 32'hffff_f5a0);
    wr(CCS_SEL_VECTOR_BASE, 32'h1234_5678);
    rd(CCS_SEL_VECTOR_BASE, 32'h1234_55a0);
    trap(1'b1, 8'h33, 32'h0);
    rd(CCS_SEL_VECTOR_BASE, 32'h1234_55a0);
    proc_state_i = 32'h0;
    wr(CCS_SEL_UPPER_WORD, 32'hdead_beef);
    rd(CCS_SEL_UPPER_WORD, 32'hdead_beef);
    step();
    mul_done_i = 1'b1;
    mul_upper_i = 32'h0bad_f00d;
    step();
    mul_done_i = 1'b0;
    chk(div_upper_o, 32'h0bad_f00d);
    rd(CCS_SEL_UPPER_WORD, 32'h0bad_f00d);
    wr(CCS_SEL_ANCILLARY, 32'h3);
    chk(32'(priv_exc_o), 32'h1);
    rd(CCS_SEL_ANCILLARY, 32'h0, 1'b0);
    proc_state_i = 32'h80;
    rd(CCS_SEL_ANCILLARY, 32'h0);
    wr(CCS_SEL_ANCILLARY, 32'hffff_ffff);
    rd(CCS_SEL_ANCILLARY, 32'h3);
    chk(32'(icache_enable_o), 32'h1);
    sw_asr_num_i = 5'h1e;
    rd(CCS_SEL_ANCILLARY, 32'h0);
    sw_asr_num_i = ICACHE_CTRL_ASR;
    flush_hit_i = 1'b1;
    flush(2'b10);
    wr(CCS_SEL_ANCILLARY, 32'h1);
    flush(2'b01);
    fp_queue_busy_i = 1'b1;
    wr(CCS_SEL_FP_STATUS, 32'hffff_ffff);
    rd(CCS_SEL_FP_STATUS, 32'hcfc0_2fff | VER);
    chk(32'(relaxed_ieee_mode_o), 32'h1);
    fp_queue_busy_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(CCS_SEL_FP_STATUS, {i[1:0], 30'h0});
      chk(32'(fp_round_mode_o), 32'(i));
      step();
      fp_fcc_wr_i = 1'b1;
      fp_fcc_i = i[1:0];
      step();
      fp_fcc_wr_i = 1'b0;
      rd(CCS_SEL_FP_STATUS, {i[1:0], 18'h0, i[1:0], 10'h0} | VER);
    end
    wr(CCS_SEL_FP_STATUS, {RND_POS_INF, 30'h0800_0000});
    chk(32'(fp_round_mode_o), 32'h2);
    fpop(5'h11, 3'h1, 1'b1);
    rd(CCS_SEL_FP_STATUS, 32'h8800_4031 | VER);
    fpop(5'h02, 3'h0, 1'b0);
    rd(CCS_SEL_FP_STATUS, 32'h8800_0062 | VER);
    fp_queue_busy_i = 1'b1;
    rd(CCS_SEL_FP_STATUS, 32'h8800_2062 | VER);
    print_verdict();
  end
endmodule
